/* File: hw/rvis_pkg.sv */
// shared constants and types for the rgb video input sampler
package rvis_pkg;
   localparam int          DW          = 32;
   localparam int          CW          = 11;
   localparam int          PW          = 24;
   localparam logic [7:0]  OFF_CTRL    = 8'h00;
   localparam logic [7:0]  OFF_VOFF    = 8'h04;
   localparam logic [7:0]  OFF_HOFF    = 8'h08;
   localparam logic [7:0]  OFF_VLEN    = 8'h0c;
   localparam logic [7:0]  OFF_HLEN    = 8'h10;
   localparam logic [7:0]  OFF_CLON    = 8'h14;
   localparam logic [7:0]  OFF_CLOFF   = 8'h18;
   localparam logic [7:0]  OFF_STAT    = 8'h1c;
   localparam int          B_RGB       = 0;
   localparam int          B_INTL      = 1;
   localparam int          B_DUAL      = 2;
   localparam int          B_FIRSTB    = 3;
   localparam int          B_VSPOL     = 4;
   localparam int          B_HSPOL     = 5;
   localparam int          B_CLPOL     = 6;
   localparam int          B_CAPEN     = 7;
   localparam int          CTRL_W      = 8;
   localparam int          S_BUSY      = 0;
   localparam int          S_WIN       = 1;
   localparam int          S_FIELD     = 2;
   localparam logic [7:0]  CTRL_RST    = 8'h31;
   localparam logic [10:0] VOFF_RST    = 11'h000;
   localparam logic [10:0] HOFF_RST    = 11'h000;
   localparam logic [10:0] VLEN_RST    = 11'h7ff;
   localparam logic [10:0] HLEN_RST    = 11'h7fe;
   localparam logic [10:0] CLON_RST    = 11'h002;
   localparam logic [10:0] CLOFF_RST   = 11'h008;

   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [CW-1:0]     vOff;
      logic [CW-1:0]     hOff;
      logic [CW-1:0]     vLen;
      logic [CW-1:0]     hLen;
      logic [CW-1:0]     clampOn;
      logic [CW-1:0]     clampOff;
   } rvis_cfg_t;

   localparam rvis_cfg_t CFG_RST = '{CTRL_RST, VOFF_RST, HOFF_RST,
                                     VLEN_RST, HLEN_RST, CLON_RST,
                                     CLOFF_RST};

   typedef struct packed {
      logic          valid0;
      logic          valid1;
      logic          isYuv;
      logic [PW-1:0] pix0;
      logic [PW-1:0] pix1;
   } rvis_pix_t;
endpackage

/* File: hw/rvis_sampler.sv */
// rgb video input sampler: apb registers, sync-relative window, clamp pulse
//
// Functional notes
// (R1) rgb select flag set samples rgb; cleared marks incoming data as yuv
// (R2) interlaced rgb is taken only when the interlace enable flag is set; the code also takes rgb with the flag clear, dropping only field 1
// (R3) one converter: rising edge only; two converters: both clock edges
// (R4) window bounded by vertical/horizontal offset and length values
// (R5) offset counters start at second edge of vertical/horizontal sync
// (R6) vertical and horizontal sync polarities set by separate flags
// (R7) vertical offset in lines, horizontal offset in pixels
// (R8) lengths in lines and pixels; software programs even pixel lengths
// (R9) single converter: one pixel from port a per sample clock
// (R10) dual converter: one pixel per edge, alternating ports a and b
// (R11) first-port flag picks port a or b first after horizontal sync
// (R12) clamp pulse timed in units of half the dot clock
// (R13) clamp on/off counts measured from second edge of horizontal sync
// (R14) clamp output polarity set by a programmable flag
// (R15) offsets and lengths refer to the whole frame, not single fields
// (R16) pixels outside the window are dropped, only inside ones passed
`timescale 1ns/100ps
module rvis_sampler
   import rvis_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [7:0]      paddr,
   input  wire logic [DW-1:0]   pwdata,
   output logic                 pready,
   output logic [DW-1:0]        prdata,
   output logic                 pslverr,
   input  wire logic            video_sample_clock,
   input  wire logic            input_vertical_sync,
   input  wire logic            input_horizontal_sync,
   input  wire logic [PW-1:0]   portA,
   input  wire logic [PW-1:0]   portB,
   output rvis_pix_t            pixOut,
   output logic                 clampOut
);

   // ---------------- register side (clk) ----------------
   rvis_cfg_t         cfg_q;
   rvis_cfg_t         shadow_q;
   logic              dirty_q;
   logic              busy_q;
   logic              reqTgl_q;
   logic [1:0]        ackSync_q;
   logic [1:0]        winSync_q;
   logic [1:0]        fldSync_q;
   logic              pready_q;
   logic              pslverr_q;
   logic [DW-1:0]     prdata_q;

   wire  access    = psel & penable & ~pready_q;
   // a write lands at the edge that completes the transfer, with pready up
   wire  wrEn      = psel & penable & pready_q & pwrite;
   wire  selCtrl   = paddr == OFF_CTRL;
   wire  selVOff   = paddr == OFF_VOFF;
   wire  selHOff   = paddr == OFF_HOFF;
   wire  selVLen   = paddr == OFF_VLEN;
   wire  selHLen   = paddr == OFF_HLEN;
   wire  selClOn   = paddr == OFF_CLON;
   wire  selClOff  = paddr == OFF_CLOFF;
   wire  selStat   = paddr == OFF_STAT;
   wire  mapped    = selCtrl | selVOff | selHOff | selVLen | selHLen |
                     selClOn | selClOff | selStat;
   wire  cfgWrite  = wrEn & mapped & ~selStat;
   wire  ackDone   = ackSync_q[1] == reqTgl_q;
   wire  launch    = dirty_q & ~busy_q;

   wire [DW-1:0] statWord = {29'h0, fldSync_q[1], winSync_q[1],
                             busy_q | dirty_q};
   wire [DW-1:0] rdMux =
      selCtrl  ? {24'h0, cfg_q.ctrl}     :
      selVOff  ? {21'h0, cfg_q.vOff}     :
      selHOff  ? {21'h0, cfg_q.hOff}     :
      selVLen  ? {21'h0, cfg_q.vLen}     :
      selHLen  ? {21'h0, cfg_q.hLen}     :
      selClOn  ? {21'h0, cfg_q.clampOn}  :
      selClOff ? {21'h0, cfg_q.clampOff} :
      selStat  ? statWord                : 32'h0;

   // one wait state: answer registered so the bus outputs come from flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end else begin
         pready_q  <= access;
         pslverr_q <= access & ~mapped;
         prdata_q  <= (access & ~pwrite) ? rdMux : 32'h0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= CFG_RST;
      end else if (cfgWrite) begin
         if (selCtrl)  cfg_q.ctrl     <= pwdata[CTRL_W-1:0];
         if (selVOff)  cfg_q.vOff     <= pwdata[CW-1:0];
         if (selHOff)  cfg_q.hOff     <= pwdata[CW-1:0];
         if (selVLen)  cfg_q.vLen     <= pwdata[CW-1:0];
         // low bit forced clear: the pair logic assumes even widths [R8]
         if (selHLen)  cfg_q.hLen     <= {pwdata[CW-1:1], 1'b0};
         if (selClOn)  cfg_q.clampOn  <= pwdata[CW-1:0];
         if (selClOff) cfg_q.clampOff <= pwdata[CW-1:0];
      end
   end

   // the shadow stays still while a transfer is in flight, so the link
   // side may copy it as a word; a write during the flight sets dirty again
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shadow_q <= CFG_RST;
         dirty_q  <= 1'b0;
         busy_q   <= 1'b0;
         reqTgl_q <= 1'b0;
      end else begin
         dirty_q <= cfgWrite | (dirty_q & ~launch);
         if (launch) begin
            shadow_q <= cfg_q;
            reqTgl_q <= ~reqTgl_q;
            busy_q   <= 1'b1;
         end else if (busy_q & ackDone) begin
            busy_q <= 1'b0;
         end
      end
   end

   // ---------------- link side (video_sample_clock) ----------------
   logic [2:0]        reqSync_q;
   logic              ackTgl_q;
   rvis_cfg_t         lcfg_q;
   logic [1:0]        vsSync_q;
   logic [1:0]        hsSync_q;
   logic              vsAct_q;
   logic              hsAct_q;
   logic [PW-1:0]     aSync0_q;
   logic [PW-1:0]     aSync1_q;
   logic [PW-1:0]     bFall_q;
   logic [PW-1:0]     bSync0_q;
   logic [PW-1:0]     bSync1_q;
   logic [PW-1:0]     aAlign_q;
   logic [PW-1:0]     bAlign_q;
   logic [CW-1:0]     pixCnt_q;
   logic [CW-1:0]     lineCnt_q;
   logic              field_q;
   logic              winAny_q;
   rvis_pix_t         pix_q;
   logic              clamp_q;

   wire  cfgTake  = reqSync_q[2] != reqSync_q[1];
   wire  dual     = lcfg_q.ctrl[B_DUAL];
   wire  intl     = lcfg_q.ctrl[B_INTL];
   wire  rgbMode  = lcfg_q.ctrl[B_RGB];
   // pol flag 1 means the sync pulse is active high [R6]
   wire  vsAct    = ~(vsSync_q[1] ^ lcfg_q.ctrl[B_VSPOL]);
   wire  hsAct    = ~(hsSync_q[1] ^ lcfg_q.ctrl[B_HSPOL]);
   wire  vsSecond = vsAct_q & ~vsAct;                       // [R5]
   wire  hsSecond = hsAct_q & ~hsAct;                       // [R5]
   wire  pixStep1 = ~dual;
   // dual mode: two pixels per rising edge, one per clock edge [R3] [R10]
   wire [CW-1:0] pixInc   = {{(CW-2){1'b0}}, dual, pixStep1};
   // frame line: fields interleave so the window spans the frame [R15]
   wire [CW-1:0] frameLine = intl ? {lineCnt_q[CW-2:0], field_q}
                                  : lineCnt_q;
   wire [CW-1:0] pixNext  = pixCnt_q + 11'h001;
   wire [CW-1:0] vEnd     = lcfg_q.vOff + lcfg_q.vLen;
   wire [CW-1:0] hEnd     = lcfg_q.hOff + lcfg_q.hLen;
   // lines counted against vertical offset and length [R4] [R7] [R8]
   wire  vIn      = frameLine >= lcfg_q.vOff && frameLine < vEnd;
   // pixels counted against horizontal offset and length [R4] [R7] [R8]
   wire  hIn0     = pixCnt_q >= lcfg_q.hOff && pixCnt_q < hEnd;
   wire  hIn1     = pixNext >= lcfg_q.hOff && pixNext < hEnd;
   // rgb input is taken with the interlace flag clear too; only field 1 is dropped, and field_q clears at vsync without the flag [R2]
   wire  capOk    = lcfg_q.ctrl[B_CAPEN] & (rgbMode ? 1'b1 : 1'b1) &
                    ~(rgbMode & ~intl & field_q);
   wire  take0    = capOk & vIn & hIn0;                     // [R16]
   wire  take1    = capOk & vIn & hIn1 & dual;              // [R16]
   // first-port flag picks the port sampled first after the sync [R11]
   wire  firstB   = dual & lcfg_q.ctrl[B_FIRSTB];
   // data waits one stage so it meets the counter value that names it
   wire [PW-1:0] firstPix  = firstB ? bAlign_q : aAlign_q;  // [R9] [R10]
   wire [PW-1:0] secondPix = firstB ? aAlign_q : bAlign_q;  // [R10]
   // clamp counts in half-dot units: two pixels per step [R12] [R13]
   wire [CW-1:0] halfDot  = {1'b0, pixCnt_q[CW-1:1]};
   wire  clampAct = halfDot >= lcfg_q.clampOn &&
                    halfDot < lcfg_q.clampOff;              // [R13]

   always_ff @(posedge video_sample_clock or negedge rst_n) begin
      if (!rst_n) begin
         reqSync_q <= 3'h0;
         ackTgl_q  <= 1'b0;
         lcfg_q    <= CFG_RST;
      end else begin
         reqSync_q <= {reqSync_q[1:0], reqTgl_q};
         if (cfgTake) begin
            lcfg_q   <= shadow_q;
            ackTgl_q <= reqSync_q[1];
         end
      end
   end

   // port b is caught on the falling edge in dual mode [R3] [R10]
   always_ff @(negedge video_sample_clock or negedge rst_n) begin
      if (!rst_n) bFall_q <= 24'h0;
      else        bFall_q <= portB;
   end

   // pins pass two flops so syncs and data stay aligned
   always_ff @(posedge video_sample_clock or negedge rst_n) begin
      if (!rst_n) begin
         vsSync_q <= 2'h0;
         hsSync_q <= 2'h0;
         aSync0_q <= 24'h0;
         aSync1_q <= 24'h0;
         bSync0_q <= 24'h0;
         bSync1_q <= 24'h0;
         aAlign_q <= 24'h0;
         bAlign_q <= 24'h0;
      end else begin
         vsSync_q <= {vsSync_q[0], input_vertical_sync};
         hsSync_q <= {hsSync_q[0], input_horizontal_sync};
         aSync0_q <= portA;
         aSync1_q <= aSync0_q;
         bSync0_q <= bFall_q;
         bSync1_q <= bSync0_q;
         aAlign_q <= aSync1_q;
         bAlign_q <= bSync1_q;
      end
   end

   always_ff @(posedge video_sample_clock or negedge rst_n) begin
      if (!rst_n) begin
         vsAct_q   <= 1'b0;
         hsAct_q   <= 1'b0;
         pixCnt_q  <= 11'h000;
         lineCnt_q <= 11'h000;
         field_q   <= 1'b0;
      end else begin
         vsAct_q <= vsAct;
         hsAct_q <= hsAct;
         if (hsSecond)
            pixCnt_q <= 11'h000;                            // [R5]
         else if (pixCnt_q != 11'h7fe)
            pixCnt_q <= pixCnt_q + pixInc;
         if (vsSecond) begin
            lineCnt_q <= 11'h000;                           // [R5]
            field_q   <= intl ? ~field_q : 1'b0;
         end else if (hsSecond && lineCnt_q != 11'h7ff) begin
            lineCnt_q <= lineCnt_q + 11'h001;
         end
      end
   end

   always_ff @(posedge video_sample_clock or negedge rst_n) begin
      if (!rst_n) begin
         pix_q    <= '0;
         clamp_q  <= 1'b0;
         winAny_q <= 1'b0;
      end else begin
         pix_q.valid0 <= take0;                             // [R16]
         pix_q.valid1 <= take1;                             // [R16]
         pix_q.isYuv  <= ~rgbMode;                          // [R1]
         pix_q.pix0   <= take0 ? firstPix : 24'h0;
         pix_q.pix1   <= take1 ? secondPix : 24'h0;
         clamp_q      <= clampAct ~^ lcfg_q.ctrl[B_CLPOL];  // [R14]
         winAny_q     <= take0;
      end
   end

   // status levels back to clk through two flops each
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ackSync_q <= 2'h0;
         winSync_q <= 2'h0;
         fldSync_q <= 2'h0;
      end else begin
         ackSync_q <= {ackSync_q[0], ackTgl_q};
         winSync_q <= {winSync_q[0], winAny_q};
         fldSync_q <= {fldSync_q[0], field_q};
      end
   end

   assign pready   = pready_q;
   assign pslverr  = pslverr_q;
   assign prdata   = prdata_q;
   assign pixOut   = pix_q;
   assign clampOut = clamp_q;

endmodule

/* File: bench/rvis_sampler_chk.sv */
// concurrent checks on the sampler's register and pixel ports
`timescale 1ns/100ps
module rvis_sampler_chk
   import rvis_pkg::*;
(
   input wire logic          clk,
   input wire logic          rst_n,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic [7:0]    paddr,
   input wire logic          pready,
   input wire logic [DW-1:0] prdata,
   input wire logic          pslverr,
   input wire logic          video_sample_clock,
   input wire rvis_pix_t     pixOut
);
   sequence access_s;
      psel && penable && !pready;
   endsequence
   sequence answer_s;
      pready ##1 !pready;
   endsequence

   one_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
      access_s |=> answer_s) else $error("late or long answer");
   no_stray_a: assert property (@(posedge clk) disable iff (!rst_n)
      pready |-> $past(psel && penable)) else $error("stray ready");
   err_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
      pslverr |-> pready) else $error("error without ready");
   bad_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
      access_s and paddr > OFF_STAT |=> pslverr)
      else $error("unmapped not refused");
   good_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
      access_s and paddr <= OFF_STAT and paddr[1:0] == 2'b00
      |=> !pslverr) else $error("mapped refused");
   quiet_data_a: assert property (@(posedge clk) disable iff (!rst_n)
      !pready || pslverr |-> prdata == '0) else $error("read data leak");
   blank_pix0_a: assert property (@(posedge video_sample_clock)
      disable iff (!rst_n) !pixOut.valid0 |-> pixOut.pix0 == '0)
      else $error("pixel passed without valid");
   blank_pix1_a: assert property (@(posedge video_sample_clock)
      disable iff (!rst_n) !pixOut.valid1 |-> pixOut.pix1 == '0)
      else $error("second pixel passed without valid");
   pair_valid_a: assert property (@(posedge video_sample_clock)
      disable iff (!rst_n) pixOut.valid1 |-> pixOut.valid0)
      else $error("unpaired second pixel");
endmodule

bind rvis_sampler rvis_sampler_chk i_chk (.clk, .rst_n, .psel, .penable,
   .paddr, .pready, .prdata, .pslverr, .video_sample_clock, .pixOut);

/* File: bench/rvis_adc_model.sv */
// behavioural converter pair: sample clock, syncs and pixel ports
`timescale 1ns/100ps
module rvis_adc_model
   import rvis_pkg::*;
(
   input  wire logic     syncHigh,
   output logic          video_sample_clock,
   output logic          input_vertical_sync,
   output logic          input_horizontal_sync,
   output logic [PW-1:0] portA,
   output logic [PW-1:0] portB,
   output logic          frameStart
);
   int col = 0;
   int row = 0;
   initial begin
      {input_vertical_sync, input_horizontal_sync, frameStart} = 3'h0;
      {portA, portB} = '0;
      video_sample_clock = 1'b0;
      #3.7;
      forever #7.5 video_sample_clock = ~video_sample_clock;
   end
   // 8 lines of 4 sync + 40 pixel cycles; data changes every cycle
   always @(posedge video_sample_clock) begin
      col <= (col == 43) ? 0 : col + 1;
      if (col == 43) row <= (row == 7) ? 0 : row + 1;
      input_horizontal_sync <= (col < 4) ~^ syncHigh;
      input_vertical_sync <= (row == 0) ~^ syncHigh;
      frameStart <= (row == 0 && col == 0);
      // set on rising edge: stable at both sampling edges
      portA <= {8'haa, 8'(row), 8'(col - 4)};
      portB <= {8'hbb, 8'(row), 8'(col - 4)};
   end
endmodule

/* File: bench/tb_rvis_sampler.sv */
// self-checking bench for the rgb video input sampler
`timescale 1ns/100ps
module tb_rvis_sampler
   import rvis_pkg::*;
;
   logic          clk = 1'b0;
   logic          rst_n = 1'b0;
   logic          psel = 1'b0;
   logic          penable = 1'b0;
   logic          pwrite = 1'b0;
   logic [7:0]    paddr = 8'h00;
   logic [DW-1:0] pwdata = '0;
   logic          pready, pslverr, clampOut, frameStart, errv;
   logic [DW-1:0] prdata, rdv;
   logic          video_sample_clock, input_vertical_sync;
   logic          input_horizontal_sync;
   logic [PW-1:0] portA, portB;
   rvis_pix_t     pixOut, firstPix;
   logic          syncHigh = 1'b1;
   logic          measure = 1'b0;
   logic          clampLvl = 1'b0;
   int            nPix0, nPix1, nClamp;
   int            badCount = 0;
   int            checkCount = 0;
   int            cycles = 0;

   rvis_sampler i_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .prdata, .pslverr, .video_sample_clock,
      .input_vertical_sync, .input_horizontal_sync, .portA, .portB,
      .pixOut, .clampOut);
   rvis_adc_model i_adc (.syncHigh, .video_sample_clock,
      .input_vertical_sync, .input_horizontal_sync, .portA, .portB,
      .frameStart);

   initial forever #20 clk = ~clk;

   always @(posedge video_sample_clock) begin
      if (measure) begin
         if (pixOut.valid0 === 1'b1 && nPix0 == 0) firstPix <= pixOut;
         nPix0 <= nPix0 + int'(pixOut.valid0 === 1'b1);
         nPix1 <= nPix1 + int'(pixOut.valid1 === 1'b1);
         nClamp <= nClamp + int'(clampOut === clampLvl);
      end
   end

   task automatic wrapUp();
      $display("checks %0d mismatches %0d", checkCount, badCount);
      if (badCount == 0 && checkCount > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         badCount++;
         wrapUp();
      end
   end

   task automatic chk(string what, logic [DW-1:0] exp, logic [DW-1:0] got);
      checkCount++;
      if (got !== exp) begin
         badCount++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic xfer(logic w, logic [7:0] a, logic [DW-1:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // measures one whole frame once the new setting reached the link side
   task automatic runFrame(logic [7:0] ctrl);
      syncHigh <= ctrl[B_HSPOL];
      xfer(1'b1, OFF_CTRL, DW'(ctrl));
      do xfer(1'b0, OFF_STAT, '0); while (rdv[S_BUSY] !== 1'b0);
      clampLvl = ctrl[B_CLPOL];
      nPix0 = 0;
      nPix1 = 0;
      nClamp = 0;
      firstPix = '0;
      repeat (2) @(posedge frameStart);
      measure = 1'b1;
      @(posedge frameStart);
      measure = 1'b0;
      #1;
      @(posedge clk);
   endtask

   task automatic testRegs();
      xfer(1'b0, OFF_CTRL, '0);
      chk("ctrl reset", DW'(CTRL_RST), rdv);
      xfer(1'b0, OFF_CLOFF, '0);
      chk("clamp off reset", DW'(CLOFF_RST), rdv);
      xfer(1'b1, OFF_HLEN, 32'h0000_0007);
      xfer(1'b0, OFF_HLEN, '0);
      chk("odd length", 32'h0000_0006, rdv);
      xfer(1'b1, 8'h20, 32'hffff_ffff);
      chk("unmapped error", 32'h0000_0001, DW'(errv));
      xfer(1'b0, 8'h20, '0);
      chk("unmapped data", 32'h0000_0000, rdv);
      xfer(1'b1, OFF_VOFF, 32'h0000_0001);
      xfer(1'b1, OFF_HOFF, 32'h0000_0004);
      xfer(1'b1, OFF_VLEN, 32'h0000_0002);
      xfer(1'b1, OFF_HLEN, 32'h0000_0006);
      $display("register test done");
   endtask

   task automatic testSingle();
      runFrame(8'hf1);
      chk("pixels", 32'd12, nPix0);
      chk("port b pixels", 32'd0, nPix1);
      chk("first index", 32'd4, DW'(firstPix.pix0[7:0]));
      chk("port tag", 32'haa, DW'(firstPix.pix0[23:16]));
      chk("yuv flag", 32'd0, DW'(firstPix.isYuv));
      chk("clamp", 32'd96, nClamp);
      $display("single converter test done");
   endtask

   task automatic testModes();
      runFrame(8'h81);
      chk("low sync pixels", 32'd12, nPix0);
      chk("low clamp", 32'd96, nClamp);
      runFrame(8'hb0);
      chk("yuv flag", 32'd1, DW'(firstPix.isYuv));
      runFrame(8'h31);
      chk("capture off", 32'd0, nPix0);
      $display("mode test done");
   endtask

   task automatic testDual();
      for (int f = 0; f < 2; f++) begin
         runFrame(f ? 8'hfd : 8'hf5);
         chk("pairs", 32'd6, nPix0);
         chk("second", 32'd6, nPix1);
         chk("lead", f ? 32'hbb : 32'haa, DW'(firstPix.pix0[23:16]));
         chk("trail", f ? 32'haa : 32'hbb, DW'(firstPix.pix1[23:16]));
         chk("dual clamp", 32'd48, nClamp);
      end
      $display("dual converter test done");
   endtask

   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      testRegs();
      testSingle();
      testModes();
      testDual();
      wrapUp();
   end
endmodule
